// ===== hw/lane_ctrl_pkg.sv
/*
  Package for the lane control and interrupt mask register bank.
  Holds register offsets, field layouts, reset values and shared types.
  Assumes an 8-bit register port addressed by byte offset.
*/
package lane_ctrl_pkg;

  localparam int unsigned LANES     = 8;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 8;

  // Byte offsets as printed.
  localparam logic [7:0] OFF_POWER       = 8'h5D;
  localparam logic [7:0] OFF_SWING0      = 8'h5E;
  localparam logic [7:0] OFF_SWING1      = 8'h5F;
  localparam logic [7:0] OFF_SWING2      = 8'h60;
  localparam logic [7:0] OFF_SWING3      = 8'h61;
  localparam logic [7:0] OFF_RX_OUT_OFF  = 8'h62;
  localparam logic [7:0] OFF_RX_QUIET    = 8'h63;
  localparam logic [7:0] OFF_RX_INVERT   = 8'h64;
  localparam logic [7:0] OFF_TX_SKIP     = 8'h65;
  localparam logic [7:0] OFF_RX_SKIP     = 8'h66;
  localparam logic [7:0] OFF_LOSS_MASK   = 8'h67;
  // Registers placed here for the latched flags, the event status and its mask.
  localparam logic [7:0] OFF_LOSS_FLAG   = 8'hC0;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'hC1;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'hC2;

  // Power byte field positions.
  localparam int unsigned POWER_OVR_BIT  = 0;
  localparam int unsigned POWER_SET_BIT  = 1;

  // Swing codes.
  localparam logic [3:0] SWING_MAX       = 4'h7;
  localparam logic [3:0] SWING_MIN       = 4'h0;
  localparam int unsigned SWING_RSV_BIT  = 3;

  // Reset values.
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [1:0] RST_IRQ         = 2'h0;

  // Interrupt status bits.
  localparam int unsigned IRQ_LOSS_BIT   = 0;
  localparam int unsigned IRQ_SWING_BIT  = 1;

  typedef enum logic [2:0] {
    PWR_NONE = 3'b001,
    PWR_LOW  = 3'b010,
    PWR_HIGH = 3'b100
  } power_mode_t;

  typedef struct packed {
    logic [LANES-1:0]   outOff;
    logic [LANES-1:0]   quietOff;
    logic [LANES-1:0]   invert;
    logic [LANES-1:0]   txSkip;
    logic [LANES-1:0]   rxSkip;
    logic [4*LANES-1:0] swing;
  } lane_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

endpackage : lane_ctrl_pkg

// ===== hw/lane_ctrl_regs.sv
/*
  Lane control and interrupt mask register bank of an 8-lane module.
  Holds per-lane receive and transmit controls, the power override,
  latched signal-loss flags with their masks, and the interrupt pin.
  Assumes a single-cycle register port and synchronous raw alarm inputs.
*/
// Decided for this implementation: the address-and-strobe port.
// Functional notes
// - Decode power field: x0 none, 11 low, 01 high
// - Four swing bytes, odd lane high nibble
// - Swing 0111 max, 0000 min, 1xxx reserved
// - Bit n of 62h disables Rx output
// - Bit n of byte 99 stops squelch
// - Bit n of 64h inverts Rx polarity
// - Bit n of 65h bypasses Tx recovery
// - Bit n of 66h bypasses Rx recovery
// - One writable mask bit per alarm flag
// - Mask bit one blocks flag from interrupt
// - Masks volatile, reset to zero
// - Unmasking interrupts only for unread flags set
// - One interrupt per alarm occurrence
// - Byte 67h masks signal-loss lanes 7..0
`timescale 1ns/100ps
`default_nettype none

module lane_ctrl_regs
  import lane_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // Register port
  input  wire reg_req_t             regReq,
  output logic      [DATA_W-1:0]    rdData,
  // Raw alarm conditions
  input  wire logic [LANES-1:0]     signal_loss,
  // Lane controls
  output lane_ctrl_t                laneCtrl,
  output power_mode_t               powerMode,
  output logic      [LANES-1:0]     swingReserved,
  // Interrupt outputs
  output logic                      alarm_irq_n,
  output logic                      irq
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Reset synchroniser: first stage feeds only the second.
  logic rstMeta_q;
  logic rstSync_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  wire logic rstN = rstSync_q;

  // Address decode.
  wire logic wr     = regReq.wr;
  wire logic rd     = regReq.rd;
  wire logic [7:0] a  = regReq.addr;
  wire logic [7:0] wd = regReq.wdata;
  wire logic wrPower  = wr && hit(a, OFF_POWER);
  wire logic wrSw0    = wr && hit(a, OFF_SWING0);
  wire logic wrSw1    = wr && hit(a, OFF_SWING1);
  wire logic wrSw2    = wr && hit(a, OFF_SWING2);
  wire logic wrSw3    = wr && hit(a, OFF_SWING3);
  wire logic wrOut    = wr && hit(a, OFF_RX_OUT_OFF);
  wire logic wrQuiet  = wr && hit(a, OFF_RX_QUIET);
  wire logic wrInv    = wr && hit(a, OFF_RX_INVERT);
  wire logic wrTxSk   = wr && hit(a, OFF_TX_SKIP);
  wire logic wrRxSk   = wr && hit(a, OFF_RX_SKIP);
  wire logic wrMask   = wr && hit(a, OFF_LOSS_MASK);
  wire logic rdFlag   = rd && hit(a, OFF_LOSS_FLAG);
  wire logic wrStat   = wr && hit(a, OFF_IRQ_STATUS);
  wire logic wrIMask  = wr && hit(a, OFF_IRQ_MASK);

  // Control registers.
  logic [1:0]       power_q;
  logic [7:0]       swing_q [4];
  logic [LANES-1:0] outOff_q;
  logic [LANES-1:0] quietOff_q;
  logic [LANES-1:0] invert_q;
  logic [LANES-1:0] txSkip_q;
  logic [LANES-1:0] rxSkip_q;
  logic [LANES-1:0] lossMask_q;
  logic [LANES-1:0] lossFlag_q;
  logic [LANES-1:0] lossPrev_q;
  logic [1:0]       irqStat_q;
  logic [1:0]       irqMask_q;
  logic [7:0]       rdData_q;

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      power_q    <= RST_BYTE[1:0];
      swing_q[0] <= RST_BYTE;
      swing_q[1] <= RST_BYTE;
      swing_q[2] <= RST_BYTE;
      swing_q[3] <= RST_BYTE;
      outOff_q   <= RST_BYTE;
      quietOff_q <= RST_BYTE;
      invert_q   <= RST_BYTE;
      txSkip_q   <= RST_BYTE;
      rxSkip_q   <= RST_BYTE;
    end else begin
      if (wrPower) power_q <= wd[1:0];
      if (wrSw0) swing_q[0] <= wd;
      if (wrSw1) swing_q[1] <= wd;
      if (wrSw2) swing_q[2] <= wd;
      if (wrSw3) swing_q[3] <= wd;
      if (wrOut) outOff_q <= wd;
      if (wrQuiet) quietOff_q <= wd;
      if (wrInv) invert_q <= wd;
      if (wrTxSk) txSkip_q <= wd;
      if (wrRxSk) rxSkip_q <= wd;
    end
  end

  // Masks are never preserved across reset.
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      lossMask_q <= RST_BYTE;
    end else if (wrMask) begin
      lossMask_q <= wd;
    end
  end

  // A flag latches on the rising edge of its condition, so a long condition
  // yields one occurrence; a read clears it, but a new edge in the same
  // cycle wins over the clear.
  wire logic [LANES-1:0] lossRise = signal_loss & ~lossPrev_q;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      lossPrev_q <= RST_BYTE;
      lossFlag_q <= RST_BYTE;
    end else begin
      lossPrev_q <= signal_loss;
      lossFlag_q <= (rdFlag ? RST_BYTE : lossFlag_q) | lossRise;
    end
  end

  // Flags stay latched while masked, so clearing the mask exposes only
  // those set and not yet read.
  wire logic [LANES-1:0] lossPending = lossFlag_q & ~lossMask_q;
  assign alarm_irq_n = ~|lossPending;

  // Sticky event status: new unmasked signal loss and reserved swing write.
  wire logic swingRsvWr = (wrSw0 | wrSw1 | wrSw2 | wrSw3) && (wd[7] | wd[3]);
  wire logic [1:0] irqEvt = {swingRsvWr, |(lossRise & ~lossMask_q)};
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      irqStat_q <= RST_IRQ;
      irqMask_q <= RST_IRQ;
    end else begin
      irqStat_q <= (irqStat_q & ~(wrStat ? wd[1:0] : RST_IRQ)) | irqEvt;
      if (wrIMask) irqMask_q <= wd[1:0];
    end
  end
  assign irq = |(irqStat_q & irqMask_q);

  // Power override decode.
  always_comb begin
    if (!power_q[POWER_OVR_BIT])
      powerMode = PWR_NONE;
    else if (power_q[POWER_SET_BIT])
      powerMode = PWR_LOW;
    else
      powerMode = PWR_HIGH;
  end

  // Lane outputs; reserved swing codes are flagged and clamped to maximum.
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_sw
      wire logic [3:0] ev = swing_q[i][3:0];
      wire logic [3:0] od = swing_q[i][7:4];
      assign swingReserved[2*i]   = ev[SWING_RSV_BIT];
      assign swingReserved[2*i+1] = od[SWING_RSV_BIT];
      assign laneCtrl.swing[8*i+:4]   = ev[SWING_RSV_BIT] ? SWING_MAX : ev;
      assign laneCtrl.swing[8*i+4+:4] = od[SWING_RSV_BIT] ? SWING_MAX : od;
    end
  endgenerate
  assign laneCtrl.outOff   = outOff_q;
  assign laneCtrl.quietOff = quietOff_q;
  assign laneCtrl.invert   = invert_q;
  assign laneCtrl.txSkip   = txSkip_q;
  assign laneCtrl.rxSkip   = rxSkip_q;

  // Read mux; unmapped addresses read zero.
  logic [7:0] rdMux;
  always_comb begin
    if (hit(a, OFF_POWER))           rdMux = {6'h00, power_q};
    else if (hit(a, OFF_SWING0))     rdMux = swing_q[0];
    else if (hit(a, OFF_SWING1))     rdMux = swing_q[1];
    else if (hit(a, OFF_SWING2))     rdMux = swing_q[2];
    else if (hit(a, OFF_SWING3))     rdMux = swing_q[3];
    else if (hit(a, OFF_RX_OUT_OFF)) rdMux = outOff_q;
    else if (hit(a, OFF_RX_QUIET))   rdMux = quietOff_q;
    else if (hit(a, OFF_RX_INVERT))  rdMux = invert_q;
    else if (hit(a, OFF_TX_SKIP))    rdMux = txSkip_q;
    else if (hit(a, OFF_RX_SKIP))    rdMux = rxSkip_q;
    else if (hit(a, OFF_LOSS_MASK))  rdMux = lossMask_q;
    else if (hit(a, OFF_LOSS_FLAG))  rdMux = lossFlag_q;
    else if (hit(a, OFF_IRQ_STATUS)) rdMux = {6'h00, irqStat_q};
    else if (hit(a, OFF_IRQ_MASK))   rdMux = {6'h00, irqMask_q};
    else                             rdMux = 8'h00;
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) rdData_q <= RST_BYTE;
    else       rdData_q <= rd ? rdMux : RST_BYTE;
  end
  assign rdData = rdData_q;

endmodule : lane_ctrl_regs

`default_nettype wire

// ===== verif/lane_ctrl_regs_asserts.sv
/* Checker for the lane control bank.
   Assumes it sees only the top ports; loss masks are followed from writes. */
`timescale 1ns/100ps
`default_nettype none
module lane_ctrl_regs_asserts
  import lane_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic             core_clk,
  input wire logic             rst_n,
  // Register port
  input wire reg_req_t         regReq,
  input wire logic [7:0]       rdData,
  // Alarms, controls, interrupts
  input wire logic [LANES-1:0] signal_loss,
  input wire lane_ctrl_t       laneCtrl,
  input wire power_mode_t      powerMode,
  input wire logic [LANES-1:0] swingReserved,
  input wire logic             alarm_irq_n,
  input wire logic             irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] mask_q;
  wire logic [7:0] a = regReq.addr;
  wire logic       w = regReq.wr;
  // The mask byte is not visible at the ports, so a shadow follows its writes.
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      mask_q <= 8'h00;
    else if (w && a == OFF_LOSS_MASK)
      mask_q <= regReq.wdata;
  read_idle_a: assert property (!$past(regReq.rd) |-> rdData == 8'h00) else $error("stray read data");
  out_off_a: assert property (w && a == OFF_RX_OUT_OFF |=> laneCtrl.outOff == $past(regReq.wdata))
    else $error("output off wrong");
  quiet_off_a: assert property (w && a == OFF_RX_QUIET |=> laneCtrl.quietOff == $past(regReq.wdata))
    else $error("squelch off wrong");
  power_mode_a: assert property (w && a == OFF_POWER |=> powerMode ==
    (!$past(regReq.wdata[0]) ? PWR_NONE : $past(regReq.wdata[1]) ? PWR_LOW : PWR_HIGH)) else $error("power wrong");
  swing_pair_a: assert property (w && a == OFF_SWING0 && !regReq.wdata[7] && !regReq.wdata[3]
    |=> laneCtrl.swing[7:0] == $past(regReq.wdata)) else $error("swing wrong");
  swing_rsv_a: assert property (w && a == OFF_SWING3 |=>
    swingReserved[7:6] == {$past(regReq.wdata[7]), $past(regReq.wdata[3])}) else $error("reserved flag wrong");
  loss_irq_a: assert property (|(signal_loss & ~$past(signal_loss) & ~mask_q) && !(w && a == OFF_LOSS_MASK)
    |=> !alarm_irq_n) else $error("loss did not interrupt");
  reset_out_a: assert property ($rose(rst_n) |-> alarm_irq_n && !irq && powerMode == PWR_NONE)
    else $error("reset state wrong");
  pin_c: cover property (!alarm_irq_n);
  irq_c: cover property (irq);
  read_c: cover property (regReq.rd ##1 rdData != 8'h00);
endmodule : lane_ctrl_regs_asserts
bind lane_ctrl_regs lane_ctrl_regs_asserts chk_u (.core_clk(core_clk), .rst_n(rst_n), .regReq(regReq),
  .rdData(rdData), .signal_loss(signal_loss), .laneCtrl(laneCtrl), .powerMode(powerMode),
  .swingReserved(swingReserved), .alarm_irq_n(alarm_irq_n), .irq(irq));
`default_nettype wire

// ===== verif/host_ctrl_model.sv
/* Host management controller model driving the register port.
   Assumes its tasks are called right after a rising clock edge. */
`timescale 1ns/100ps
`default_nettype none
module host_ctrl_model
  import lane_ctrl_pkg::*;
(
  // Clock
  input  wire logic       core_clk,
  // Register port
  output var  reg_req_t   regReq,
  input  wire logic [7:0] rdData
);
  initial regReq = '0;
  // Each call leaves one idle cycle, so no strobe is set twice in one step.
  task automatic wrReg(input logic [7:0] addr, input logic [7:0] data);
    regReq <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    regReq <= '0;
    @(posedge core_clk);
  endtask : wrReg
  task automatic rdReg(input logic [7:0] addr, output logic [7:0] data);
    regReq <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    regReq <= '0;
    #1;
    data = rdData;
    @(posedge core_clk);
  endtask : rdReg
endmodule : host_ctrl_model
`default_nettype wire

// ===== verif/tb_top.sv
/* Bench for the lane control bank.
   Assumes the host model owns the register port; the bench drives loss inputs. */
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import lane_ctrl_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  signal_loss = 8'h00;
  reg_req_t    regReq;
  logic [7:0]  rdData;
  lane_ctrl_t  laneCtrl;
  power_mode_t powerMode;
  logic [7:0]  swingReserved;
  logic        alarm_irq_n;
  logic        irq;
  logic [7:0]  rv;
  int          errors = 0;
  int          comparisons = 0;
  initial forever #10 core_clk = ~core_clk;
  host_ctrl_model host_u (.core_clk(core_clk), .regReq(regReq), .rdData(rdData));
  lane_ctrl_regs dut_u (.core_clk(core_clk), .rst_n(rst_n), .regReq(regReq), .rdData(rdData),
    .signal_loss(signal_loss), .laneCtrl(laneCtrl), .powerMode(powerMode),
    .swingReserved(swingReserved), .alarm_irq_n(alarm_irq_n), .irq(irq));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp);
    host_u.rdReg(addr, rv);
    chk("read data", exp, rv);
  endtask : rdChk
  // Sampled mid-cycle so a registered pin update cannot race the check.
  task automatic pinChk(input logic pin, input logic irqExp);
    @(negedge core_clk);
    chk("pin and irq", {6'h00, pin, irqExp}, {6'h00, alarm_irq_n, irq});
    @(posedge core_clk);
  endtask : pinChk
  task automatic t_lanes;
    logic [7:0] pat [5] = '{8'h81, 8'h42, 8'h24, 8'h18, 8'hC3};
    logic [7:0] got [5];
    pinChk(1'b1, 1'b0);
    rdChk(OFF_LOSS_MASK, 8'h00);
    rdChk(8'h10, 8'h00);
    for (int i = 0; i < 5; i++)
      host_u.wrReg(OFF_RX_OUT_OFF + 8'(i), pat[i]);
    got = '{laneCtrl.outOff, laneCtrl.quietOff, laneCtrl.invert, laneCtrl.txSkip, laneCtrl.rxSkip};
    for (int i = 0; i < 5; i++) begin
      chk("lane bits", pat[i], got[i]);
      rdChk(OFF_RX_OUT_OFF + 8'(i), pat[i]);
    end
    $display("lane test done");
  endtask : t_lanes
  task automatic t_swing_power;
    power_mode_t exp [4] = '{PWR_NONE, PWR_HIGH, PWR_NONE, PWR_LOW};
    host_u.wrReg(OFF_SWING0, 8'h70);
    host_u.wrReg(OFF_SWING3, 8'h93);
    chk("swing 1:0", 8'h70, laneCtrl.swing[7:0]);
    chk("swing 7:6", 8'h73, laneCtrl.swing[31:24]);
    chk("reserved", 8'h80, swingReserved);
    for (int c = 0; c < 4; c++) begin
      host_u.wrReg(OFF_POWER, 8'(c));
      chk("power", {5'h00, exp[c]}, {5'h00, powerMode});
    end
    $display("swing and power test done");
  endtask : t_swing_power
  task automatic t_alarms;
    signal_loss <= 8'h04;
    @(posedge core_clk);
    pinChk(1'b0, 1'b0);
    rdChk(OFF_LOSS_FLAG, 8'h04);
    repeat (3) @(posedge core_clk);
    pinChk(1'b1, 1'b0);
    host_u.wrReg(OFF_LOSS_MASK, 8'h08);
    signal_loss <= 8'h0C;
    repeat (2) @(posedge core_clk);
    pinChk(1'b1, 1'b0);
    host_u.wrReg(OFF_LOSS_MASK, 8'h00);
    pinChk(1'b0, 1'b0);
    rdChk(OFF_LOSS_FLAG, 8'h08);
    pinChk(1'b1, 1'b0);
    host_u.wrReg(OFF_IRQ_MASK, 8'h01);
    pinChk(1'b1, 1'b1);
    host_u.wrReg(OFF_IRQ_STATUS, 8'h01);
    pinChk(1'b1, 1'b0);
    rdChk(OFF_IRQ_STATUS, 8'h02);
    signal_loss <= 8'h00;
    $display("alarm test done");
  endtask : t_alarms
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    errors++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_lanes;
    t_swing_power;
    t_alarms;
    print_verdict;
  end
endmodule : tb_top
`default_nettype wire
